// *** logic/eeprom_slave_pkg.sv ***
package eeprom_slave_pkg;
	// ----------------------------------------------------------------
	// select byte layout
	// ----------------------------------------------------------------
	// memory type code; value arbitrary, set per product
	localparam logic [3:0] TYPE_CODE = 4'h5;
	localparam int TYPE_MSB = 7;
	localparam int TYPE_LSB = 4;
	localparam int STRAP_MSB = 3;
	localparam int STRAP_LSB = 1;
	localparam int DIR_BIT = 0;
	localparam logic DIR_READ = 1'b1;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	// internal write cycle length, in microseconds
	localparam int WRITE_TIME_US = 5;
	localparam int WRITE_CYCLES = WRITE_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int FILTER_LEN = 3;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [3:0] BITCNT_RESET = 4'h0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SELECT = 3'b001,
		ST_ADDR_HI = 3'b010,
		ST_ADDR_LO = 3'b011,
		ST_WDATA = 3'b100,
		ST_RDATA = 3'b101,
		ST_WRITING = 3'b110
	} phase_t;
endpackage

// *** logic/line_filter.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// two-flop synchroniser followed by a glitch filter that needs every history bit to agree
// ----------------------------------------------------------------
module line_filter #(
	parameter int LEN = 3
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// raw pin and filtered level
	input wire logic pin,
	output logic level
);
	logic meta_q;
	logic sync_q;
	logic [LEN-1:0] hist_q;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
		end
	end

	// the level only moves once the history agrees, so spikes shorter than LEN cycles vanish
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hist_q <= '1;
			level <= 1'b1;
		end else begin
			hist_q <= {hist_q[LEN-2:0], sync_q};
			if (&hist_q) begin
				level <= 1'b1;
			end else if (~|hist_q) begin
				level <= 1'b0;
			end
		end
	end
endmodule

// *** logic/eeprom_two_wire_slave.sv ***
`timescale 1ns/1ps
module eeprom_two_wire_slave #(
	parameter int WRITE_CYCLES = eeprom_slave_pkg::WRITE_CYCLES,
	parameter int FILTER_LEN = eeprom_slave_pkg::FILTER_LEN
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// two-wire bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// straps and protection (pull-downs outside make floating pins low)
	input wire logic strap_addr_bit0,
	input wire logic strap_addr_bit1,
	input wire logic strap_addr_bit2,
	input wire logic write_protect_in,
	// array side
	input wire logic [7:0] read_data,
	output logic [15:0] mem_addr,
	output logic [7:0] write_data,
	output logic write_strobe,
	output logic read_strobe,
	output logic write_busy,
	output logic selected
);
	// ----------------------------------------------------------------
	// line conditioning
	// ----------------------------------------------------------------
	logic scl_f;
	logic sda_f;
	logic scl_prev_q;
	logic sda_prev_q;
	logic wp_meta_q;
	logic wp_q;
	logic [2:0] strap_meta_q;
	logic [2:0] strap_q;

	line_filter #(.LEN(FILTER_LEN)) u_scl_filter (
		.mclk(mclk),
		.nrst(nrst),
		.pin(scl_in),
		.level(scl_f)
	);

	line_filter #(.LEN(FILTER_LEN)) u_sda_filter (
		.mclk(mclk),
		.nrst(nrst),
		.pin(sda_in),
		.level(sda_f)
	);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
			wp_meta_q <= 1'b0;
			wp_q <= 1'b0;
			strap_meta_q <= 3'h0;
			strap_q <= 3'h0;
		end else begin
			scl_prev_q <= scl_f;
			sda_prev_q <= sda_f;
			wp_meta_q <= write_protect_in;
			wp_q <= wp_meta_q;
			strap_meta_q <= {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
			strap_q <= strap_meta_q;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	assign scl_rise = scl_f & ~scl_prev_q;
	assign scl_fall = ~scl_f & scl_prev_q;
	assign start_det = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
	assign stop_det = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

	// ----------------------------------------------------------------
	// bit and byte framing
	// ----------------------------------------------------------------
	eeprom_slave_pkg::phase_t phase_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic ack_drive_q;
	logic master_nack_q;
	logic data_ack_q;
	logic ack_pend_q;
	logic rd_low_q;
	logic [31:0] wr_timer_q;

	logic in_ack;
	logic byte_done;
	logic sel_match;
	logic [7:0] rx_byte;
	logic writing;

	function automatic logic select_matches(input logic [7:0] sb, input logic [2:0] straps);
		select_matches = (sb[eeprom_slave_pkg::TYPE_MSB:eeprom_slave_pkg::TYPE_LSB] == eeprom_slave_pkg::TYPE_CODE)
			&& (sb[eeprom_slave_pkg::STRAP_MSB:eeprom_slave_pkg::STRAP_LSB] == straps);
	endfunction

	assign writing = (phase_q == eeprom_slave_pkg::ST_WRITING);
	assign in_ack = (bit_cnt_q == 4'h8); // ninth clock pulse
	assign rx_byte = {shift_q[6:0], sda_f}; // msb first
	assign byte_done = scl_rise && (bit_cnt_q == 4'h7);
	assign sel_match = select_matches(rx_byte, strap_q);

	// bit counter counts 0..7 data bits, 8 is the acknowledge slot
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bit_cnt_q <= eeprom_slave_pkg::BITCNT_RESET;
			shift_q <= eeprom_slave_pkg::BYTE_RESET;
			master_nack_q <= 1'b0;
		end else if (start_det || stop_det) begin
			bit_cnt_q <= eeprom_slave_pkg::BITCNT_RESET;
		end else if (scl_rise && !writing) begin
			if (in_ack) begin
				bit_cnt_q <= eeprom_slave_pkg::BITCNT_RESET;
				master_nack_q <= sda_f;
			end else begin
				bit_cnt_q <= bit_cnt_q + 4'h1;
				shift_q <= rx_byte;
			end
		end
	end

	// ----------------------------------------------------------------
	// transfer phase
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			phase_q <= eeprom_slave_pkg::ST_IDLE;
			ack_drive_q <= 1'b0;
			ack_pend_q <= 1'b0;
			data_ack_q <= 1'b0;
			wr_timer_q <= 32'h0;
		end else begin
			case (phase_q)
				eeprom_slave_pkg::ST_WRITING: begin
					// deaf to the bus until the cycle ends
					if (wr_timer_q >= 32'(WRITE_CYCLES - 1)) begin
						phase_q <= eeprom_slave_pkg::ST_IDLE;
						wr_timer_q <= 32'h0;
					end else begin
						wr_timer_q <= wr_timer_q + 32'h1;
					end
				end
				default: begin
					if (start_det) begin
						phase_q <= eeprom_slave_pkg::ST_SELECT;
						data_ack_q <= 1'b0;
						ack_pend_q <= 1'b0;
					end else if (stop_det) begin
						// the stop's own clock rise is counted, so a stop in the tenth slot sees a count of one
						if (phase_q == eeprom_slave_pkg::ST_WDATA && data_ack_q && bit_cnt_q == 4'h1) begin
							phase_q <= eeprom_slave_pkg::ST_WRITING;
						end else begin
							phase_q <= eeprom_slave_pkg::ST_IDLE;
						end
					end else if (byte_done) begin
						// decide now, drive only after the clock falls so the line never moves while it is high
						ack_pend_q <= 1'b0;
						case (phase_q)
							eeprom_slave_pkg::ST_SELECT: begin
								if (sel_match) begin
									ack_pend_q <= 1'b1;
									if (rx_byte[eeprom_slave_pkg::DIR_BIT] == eeprom_slave_pkg::DIR_READ) begin
										phase_q <= eeprom_slave_pkg::ST_RDATA;
									end else begin
										phase_q <= eeprom_slave_pkg::ST_ADDR_HI;
									end
								end else begin
									phase_q <= eeprom_slave_pkg::ST_IDLE;
								end
							end
							eeprom_slave_pkg::ST_ADDR_HI: begin
								ack_pend_q <= 1'b1;
								phase_q <= eeprom_slave_pkg::ST_ADDR_LO;
							end
							eeprom_slave_pkg::ST_ADDR_LO: begin
								ack_pend_q <= 1'b1;
								phase_q <= eeprom_slave_pkg::ST_WDATA;
							end
							eeprom_slave_pkg::ST_WDATA: begin
								ack_pend_q <= ~wp_q;
								data_ack_q <= data_ack_q | ~wp_q;
							end
							default: begin
							end
						endcase
					end else if (scl_fall && in_ack && phase_q == eeprom_slave_pkg::ST_RDATA && master_nack_q) begin
						phase_q <= eeprom_slave_pkg::ST_IDLE;
					end else if (scl_fall && in_ack) begin
						ack_drive_q <= ack_pend_q; // ninth slot opens
						ack_pend_q <= 1'b0;
					end else if (scl_fall && !in_ack) begin
						ack_drive_q <= 1'b0; // release after the ninth pulse
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// address, write data and read shifting
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mem_addr <= eeprom_slave_pkg::ADDR_RESET;
			write_data <= eeprom_slave_pkg::BYTE_RESET;
			write_strobe <= 1'b0;
			read_strobe <= 1'b0;
		end else begin
			write_strobe <= 1'b0;
			read_strobe <= 1'b0;
			if (byte_done && !start_det && !stop_det) begin
				case (phase_q)
					eeprom_slave_pkg::ST_ADDR_HI: mem_addr[15:8] <= rx_byte;
					eeprom_slave_pkg::ST_ADDR_LO: mem_addr[7:0] <= rx_byte;
					eeprom_slave_pkg::ST_WDATA: begin
						write_data <= rx_byte;
						if (!wp_q) begin
							write_strobe <= 1'b1; // array untouched while protected
							mem_addr <= mem_addr + 16'h1;
						end
					end
					default: begin
					end
				endcase
			end else if (scl_fall && in_ack && phase_q == eeprom_slave_pkg::ST_RDATA) begin
				read_strobe <= 1'b1; // byte handed out, advance regardless of protect
				mem_addr <= mem_addr + 16'h1;
			end
		end
	end

	// read byte loads at the falling edge that opens the ninth (acknowledge) slot, shifts on later falls
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tx_q <= eeprom_slave_pkg::BYTE_RESET;
		end else if (phase_q != eeprom_slave_pkg::ST_RDATA) begin
			tx_q <= read_data;
		end else if (scl_fall && in_ack) begin
			tx_q <= read_data;
		end else if (scl_fall && bit_cnt_q != 4'h0 && !in_ack) begin
			tx_q <= {tx_q[6:0], 1'b1};
		end
	end

	// ----------------------------------------------------------------
	// open-drain data driver
	// ----------------------------------------------------------------
	// read bits move only on falling clock edges; a change while the clock is high would look like a stop
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rd_low_q <= 1'b0;
		end else if (phase_q != eeprom_slave_pkg::ST_RDATA) begin
			rd_low_q <= 1'b0;
		end else if (scl_fall) begin
			if (in_ack) begin
				rd_low_q <= 1'b0; // line free for the master's answer
			end else if (bit_cnt_q == 4'h0) begin
				// a read continues only while the master acknowledged the previous byte
				rd_low_q <= !master_nack_q && !tx_q[7];
			end else begin
				rd_low_q <= !master_nack_q && !tx_q[6];
			end
		end
	end

	logic pull_low;
	assign pull_low = !writing && (ack_drive_q || rd_low_q);

	assign sda_out = 1'b0; // only ever pulls low
	assign sda_oe_n = ~pull_low;
	assign write_busy = writing;
	assign selected = (phase_q != eeprom_slave_pkg::ST_IDLE) && !writing;
endmodule

// *** dv/eeprom_slave_sva.sv ***
`timescale 1ns/1ps
module eeprom_slave_sva #(
	parameter int WRITE_CYCLES = 50
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// pins and status
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic write_protect_in,
	input wire logic write_strobe,
	input wire logic read_strobe,
	input wire logic write_busy,
	input wire logic selected
);
	// ----------------------------------------------------------------
	// busy length counter
	// ----------------------------------------------------------------
	int busy_cnt_q;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			busy_cnt_q <= 0;
		end else begin
			busy_cnt_q <= write_busy ? busy_cnt_q + 1 : 0;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	property p_open_drain; sda_out == 1'b0; endproperty
	a_open_drain: assert property (p_open_drain) else $error("drive value not low");
	property p_busy_quiet; write_busy |-> sda_oe_n && !selected; endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("bus answered while busy");
	property p_ack_sel; !sda_oe_n |-> selected; endproperty
	a_ack_sel: assert property (p_ack_sel) else $error("line pulled while unselected");
	property p_ack_width; $fell(sda_oe_n) |-> (!sda_oe_n) [*8]; endproperty
	a_ack_width: assert property (p_ack_width) else $error("low drive too short");
	property p_wr_pulse; write_strobe |=> !write_strobe && !read_strobe; endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
	property p_rd_pulse; read_strobe |=> !read_strobe; endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
	property p_wp_block; write_protect_in [*6] |-> !write_strobe; endproperty
	a_wp_block: assert property (p_wp_block) else $error("write while protected");
	property p_busy_len; $fell(write_busy) |-> busy_cnt_q == WRITE_CYCLES; endproperty
	a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
	property p_reset_quiet; $rose(nrst) |-> sda_oe_n [*4]; endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("drive right after reset");
endmodule

// *** dv/two_wire_master.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// bus master: makes the serial clock, 16 mclk per bit
// ----------------------------------------------------------------
module two_wire_master (
	// clock
	input wire logic mclk,
	// bus
	output logic scl,
	output logic sda_drv,
	input wire logic sda_line
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// data moves only in the low phase; sampled late in the high phase
	task automatic bit_io(input logic b, output logic r);
		sda_drv <= b;
		tick(4);
		scl <= 1'b1;
		tick(7);
		r = sda_line;
		tick(1);
		scl <= 1'b0;
		tick(4);
	endtask
	// data is raised while the clock is still low, so a slave still holding its ack never sees a stop
	task automatic start();
		sda_drv <= 1'b1;
		tick(8);
		scl <= 1'b1;
		tick(8);
		sda_drv <= 1'b0;
		tick(8);
		scl <= 1'b0;
		tick(4);
	endtask
	task automatic stop();
		sda_drv <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sda_drv <= 1'b1;
		tick(4);
	endtask
	// msb first, line released in the ninth slot
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic recv(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(!ack, r);
	endtask
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; $display("unexpected %s exp %h seen %h", n, e, g); end end
module tb_top;
	logic mclk, nrst, scl, sda_drv, sda_out, sda_oe_n, wp, write_strobe, read_strobe, write_busy, selected, ack;
	logic [2:0] strap;
	logic [7:0] read_data, write_data, d;
	logic [15:0] mem_addr, a;
	logic [31:0] seed;
	int err_total, cmp_count;
	// pull-up on the data line
	wire sda_line = sda_drv & (sda_oe_n | sda_out);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] mem_byte(input logic [15:0] x);
		return x[15:8] ^ x[7:0] ^ 8'h3c;
	endfunction
	function automatic logic [7:0] sel(input logic [2:0] s, input logic rd);
		return {eeprom_slave_pkg::TYPE_CODE, s, rd};
	endfunction
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) read_data <= mem_byte(mem_addr);
	two_wire_master i_mst (.mclk(mclk), .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
	eeprom_two_wire_slave #(.WRITE_CYCLES(400)) i_dut (.mclk(mclk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]),
		.strap_addr_bit2(strap[2]), .write_protect_in(wp), .read_data(read_data), .mem_addr(mem_addr),
		.write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
		.write_busy(write_busy), .selected(selected));
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic addr_phase(input logic [15:0] x);
		i_mst.start();
		i_mst.send(sel(strap, 1'b0), ack);
		`CHK("select ack", 1'b1, ack)
		i_mst.send(x[15:8], ack);
		`CHK("addr hi ack", 1'b1, ack)
		i_mst.send(x[7:0], ack);
		`CHK("addr lo ack", 1'b1, ack)
	endtask
	task automatic do_write(input logic [15:0] x, input logic [7:0] v, input logic p);
		int n;
		wp <= p;
		addr_phase(x);
		i_mst.send(v, ack);
		`CHK("data ack", !p, ack)
		if (!p) `CHK("data", v, write_data)
		if (!p) `CHK("address", x + 16'h1, mem_addr)
		i_mst.stop();
		i_mst.tick(8);
		`CHK("busy", !p, write_busy)
		i_mst.start();
		i_mst.send(sel(strap, 1'b0), ack);
		`CHK("poll ack", p, ack)
		i_mst.stop();
		for (n = 0; n < 600 && write_busy !== 1'b0; n++) @(posedge mclk);
		`CHK("busy end", 1'b0, write_busy)
		if (write_busy !== 1'b0) conclude();
	endtask
	task automatic do_read(input logic [15:0] x);
		addr_phase(x);
		i_mst.start();
		i_mst.send(sel(strap, 1'b1), ack);
		`CHK("read sel ack", 1'b1, ack)
		i_mst.recv(1'b1, d);
		`CHK("read byte", mem_byte(x), d)
		i_mst.recv(1'b0, d);
		`CHK("next byte", mem_byte(x + 16'h1), d)
		i_mst.stop();
		i_mst.tick(8);
		`CHK("selected", 1'b0, selected)
	endtask
	initial begin
		nrst = 1'b0;
		wp = 1'b0;
		seed = lfsr(32'hb6fb);
		strap = seed[2:0];
		err_total = 0;
		cmp_count = 0;
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		i_mst.tick(10);
		for (int k = 1; k < 9; k++) begin
			i_mst.start();
			i_mst.send(k < 8 ? sel(strap ^ k[2:0], 1'b0) : {~eeprom_slave_pkg::TYPE_CODE, strap, 1'b0}, ack);
			`CHK("foreign select", 1'b0, ack)
			i_mst.send(sel(strap, 1'b0), ack);
			`CHK("no start", 1'b0, ack)
			i_mst.stop();
		end
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			a = (k == 3) ? 16'hffff : seed[15:0];
			strap <= (k == 0) ? 3'h0 : seed[26:24];
			do_write(a, seed[23:16], 1'b0);
			do_write(a, seed[31:24], 1'b1);
			do_read(a);
			wp <= 1'b0;
		end
		addr_phase(seed[15:0]);
		i_mst.send(seed[23:16], ack);
		`CHK("stray data ack", 1'b1, ack)
		i_mst.bit_io(1'b1, ack);
		i_mst.stop();
		i_mst.tick(8);
		`CHK("stray stop busy", 1'b0, write_busy)
		i_mst.start();
		i_mst.send(sel(strap, 1'b1), ack);
		i_mst.bit_io(1'b1, ack);
		nrst <= 1'b0;
		i_mst.tick(2);
		`CHK("reset release", 1'b1, sda_oe_n)
		`CHK("reset idle", 1'b0, selected)
		nrst <= 1'b1;
		i_mst.stop();
		do_read(seed[31:16]);
		conclude();
	end
endmodule
bind eeprom_two_wire_slave eeprom_slave_sva #(.WRITE_CYCLES(WRITE_CYCLES)) i_sva (.mclk(mclk), .nrst(nrst),
	.sda_out(sda_out), .sda_oe_n(sda_oe_n), .write_protect_in(write_protect_in), .write_strobe(write_strobe),
	.read_strobe(read_strobe), .write_busy(write_busy), .selected(selected));
